//--- rtl/access_pkg.sv
`default_nettype none
package access_pkg;
  localparam int unsigned CNT_W = 34;
  typedef logic [CNT_W-1:0] cnt_t;

  // Clock rate and times, in their own units
  localparam longint unsigned CLK_HZ       = 64'h0000_0000_0098_9680; // 10 MHz
  localparam longint unsigned SETUP_TO_S   = 64'h0000_0000_0000_000F; // 15 s
  localparam longint unsigned GAP_S        = 64'h0000_0000_0000_0002; // 2 s
  localparam longint unsigned IND_S        = 64'h0000_0000_0000_0001; // 1 s
  localparam longint unsigned LOCK_LONG_S  = 64'h0000_0000_0000_0384; // 15 min
  localparam longint unsigned LOCK_SHORT_S = 64'h0000_0000_0000_001E; // 30 s
  localparam longint unsigned FLASH_MS     = 64'h0000_0000_0000_00FA; // 250 ms half period
  localparam longint unsigned REPLY_US     = 64'h0000_0000_0000_0064; // 100 us
  localparam longint unsigned MS_PER_S     = 64'h0000_0000_0000_03E8;
  localparam longint unsigned US_PER_S     = 64'h0000_0000_000F_4240;

  // Cycle counts
  localparam cnt_t SETUP_CYC      = cnt_t'(SETUP_TO_S * CLK_HZ);
  localparam cnt_t GAP_CYC        = cnt_t'(GAP_S * CLK_HZ);
  localparam cnt_t IND_CYC        = cnt_t'(IND_S * CLK_HZ);
  localparam cnt_t LOCK_LONG_CYC  = cnt_t'(LOCK_LONG_S * CLK_HZ);
  localparam cnt_t LOCK_SHORT_CYC = cnt_t'(LOCK_SHORT_S * CLK_HZ);
  localparam cnt_t FLASH_CYC      = cnt_t'(FLASH_MS * CLK_HZ / MS_PER_S);
  localparam cnt_t REPLY_CYC      = cnt_t'(REPLY_US * CLK_HZ / US_PER_S);
  localparam cnt_t CNT_ONE        = 34'h0_0000_0001;
  localparam cnt_t CNT_ZERO       = 34'h0_0000_0000;

  // Entry handling
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned CODE_W  = 12;
  localparam int unsigned SYNC_W  = 11;
  localparam logic [1:0]  LAST_ENTRY = 2'h3;

  // Register map
  localparam logic [11:0] CTRL_ADDR       = 12'h000;
  localparam logic [11:0] STATUS_ADDR     = 12'h004;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam int unsigned CTRL_SHORT_BIT  = 0;
  localparam int unsigned ST_STORED_BIT   = 0;
  localparam int unsigned ST_UNLOCK_BIT   = 1;
  localparam int unsigned ST_SETUP_BIT    = 2;
  localparam int unsigned ST_KEY_BIT      = 3;

  typedef enum logic [0:0] {
    SETUP_IDLE = 1'b0,
    SETUP_RUN  = 1'b1
  } setup_state_t;

  typedef enum logic [1:0] {
    KEY_WAIT    = 2'b00,
    KEY_REPLY   = 2'b01,
    KEY_CONFIRM = 2'b10
  } key_state_t;

  function automatic logic [IDX_W-1:0] low_index(input logic [DATA_W-1:0] v);
    logic [IDX_W-1:0] r;
    r = 3'h0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

//--- rtl/input_sync.sv
`timescale 1ns/100ps
`default_nettype none
module input_sync import access_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Pins and filtered levels
  input  wire logic [SYNC_W-1:0] raw,
  output logic      [SYNC_W-1:0] stable
);
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  logic [SYNC_W-1:0] agree;

  assign agree = s2_reg ~^ s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 11'h000;
      s2_reg <= 11'h000;
      s3_reg <= 11'h000;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit moves only once two stages agree, which also rejects one-cycle glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stable <= 11'h000;
    end else begin
      stable <= (agree & s2_reg) | (~agree & stable);
    end
  end
endmodule
`default_nettype wire

//--- rtl/pin_access_top.sv
`timescale 1ns/100ps
`default_nettype none
module pin_access_top import access_pkg::*; #(
  parameter cnt_t SETUP_CYCLES      = SETUP_CYC,
  parameter cnt_t GAP_CYCLES        = GAP_CYC,
  parameter cnt_t IND_CYCLES        = IND_CYC,
  parameter cnt_t LOCK_LONG_CYCLES  = LOCK_LONG_CYC,
  parameter cnt_t LOCK_SHORT_CYCLES = LOCK_SHORT_CYC,
  parameter cnt_t FLASH_CYCLES      = FLASH_CYC
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RSTN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // User side
  input  wire logic [DATA_W-1:0] DATA_LINES,
  input  wire logic              SETUP_BUTTON,
  input  wire logic              SEND,
  output logic                   STATUS_INDICATOR,
  output logic                   TX_ENABLE,
  // Key link
  input  wire logic              KEY_SERIAL_IN,
  output logic                   ENC_SERIAL_OUT
);
  logic [SYNC_W-1:0] lvl;
  logic [SYNC_W-1:0] lvl_prev_reg;
  logic [DATA_W-1:0] data_falls;
  logic              data_fall;
  logic [IDX_W-1:0]  idx;
  logic              setup_fall;
  logic              key_fall;
  logic              send_s;
  logic              send_rise;
  setup_state_t      setup_reg;
  key_state_t        key_reg;
  cnt_t              stimer_reg;
  cnt_t              flash_reg;
  cnt_t              gap_reg;
  cnt_t              idle_reg;
  cnt_t              key_cnt_reg;
  cnt_t              ind_cnt_reg;
  cnt_t              lock_limit;
  logic [1:0]        ecnt_reg;
  logic [CODE_W-1:0] entry_reg;
  logic [CODE_W-1:0] entry_next;
  logic [CODE_W-1:0] pin_reg;
  logic              stored_reg;
  logic              unlocked_reg;
  logic              key_erase;
  logic              key_ok;
  logic              activity;
  logic [31:0]       ctrl_reg;
  logic              apb_acc;

  input_sync u_sync (
    .clk    (CLOCK),
    .rst_n  (RSTN),
    .raw    ({KEY_SERIAL_IN, SEND, SETUP_BUTTON, DATA_LINES}),
    .stable (lvl)
  );

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      lvl_prev_reg <= 11'h000;
    end else begin
      lvl_prev_reg <= lvl;
    end
  end

  // A pulse counts at its falling edge, i.e. after high then low
  assign data_falls = lvl_prev_reg[DATA_W-1:0] & ~lvl[DATA_W-1:0];
  assign data_fall  = |data_falls;
  assign idx        = low_index(data_falls);
  assign setup_fall = lvl_prev_reg[8] & ~lvl[8];
  assign send_s     = lvl[9];
  assign send_rise  = lvl[9] & ~lvl_prev_reg[9];
  assign key_fall   = lvl_prev_reg[10] & ~lvl[10];
  assign entry_next = {entry_reg[CODE_W-IDX_W-1:0], idx};
  assign key_erase  = (key_reg == KEY_WAIT) && key_fall;
  assign key_ok     = (key_reg == KEY_CONFIRM) && key_fall;
  assign activity   = send_s | data_fall;
  assign lock_limit = ctrl_reg[CTRL_SHORT_BIT] ? LOCK_SHORT_CYCLES : LOCK_LONG_CYCLES;
  assign apb_acc    = PSEL & PENABLE & ~PREADY;

  // Setup mode and the shared entry shifter
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      setup_reg  <= SETUP_IDLE;
      stimer_reg <= CNT_ZERO;
      flash_reg  <= CNT_ZERO;
      ecnt_reg   <= 2'h0;
      entry_reg  <= 12'h000;
      pin_reg    <= 12'h000;
      stored_reg <= 1'b0;
    end else begin
      case (setup_reg)
        SETUP_IDLE: begin
          if (setup_fall) begin
            setup_reg  <= SETUP_RUN;
            stimer_reg <= CNT_ZERO;
            flash_reg  <= CNT_ZERO;
            ecnt_reg   <= 2'h0;
          end else if (stored_reg && !unlocked_reg && data_fall) begin
            entry_reg <= entry_next;
            ecnt_reg  <= ecnt_reg + 2'h1;
          end else if (ecnt_reg != 2'h0 && gap_reg == GAP_CYCLES - CNT_ONE) begin
            ecnt_reg <= 2'h0;
          end
        end
        SETUP_RUN: begin
          stimer_reg <= stimer_reg + CNT_ONE;
          flash_reg  <= (flash_reg == FLASH_CYCLES - CNT_ONE) ? CNT_ZERO : flash_reg + CNT_ONE;
          if (data_fall) begin
            entry_reg <= entry_next;
            ecnt_reg  <= ecnt_reg + 2'h1;
            if (ecnt_reg == LAST_ENTRY) begin
              pin_reg    <= entry_next;
              stored_reg <= 1'b1;
              setup_reg  <= SETUP_IDLE;
            end
          end else if (setup_fall || stimer_reg == SETUP_CYCLES - CNT_ONE) begin
            setup_reg <= SETUP_IDLE;
            ecnt_reg  <= 2'h0;
          end
        end
        default: begin
          setup_reg <= SETUP_IDLE;
        end
      endcase
      // Erasure is applied last so a key arriving with the fourth setup entry wins over the store
      if (key_erase) begin
        stored_reg <= 1'b0;
      end
    end
  end

  // Unlock, gap and inactivity timing
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      unlocked_reg <= 1'b0;
      gap_reg      <= CNT_ZERO;
      idle_reg     <= CNT_ZERO;
    end else begin
      gap_reg  <= data_fall ? CNT_ZERO : gap_reg + CNT_ONE;
      idle_reg <= (activity || !unlocked_reg) ? CNT_ZERO : idle_reg + CNT_ONE;
      if (key_erase) begin
        unlocked_reg <= 1'b0;
      end else if (setup_reg == SETUP_IDLE && !setup_fall && stored_reg && !unlocked_reg && data_fall
                   && ecnt_reg == LAST_ENTRY) begin
        unlocked_reg <= (entry_next == pin_reg);
      end else if (unlocked_reg && !activity && idle_reg == lock_limit - CNT_ONE) begin
        unlocked_reg <= 1'b0;
      end
    end
  end

  // A transmission needs a fresh rise of send, so entry presses cannot start one
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      TX_ENABLE <= 1'b0;
    end else begin
      TX_ENABLE <= send_s && setup_reg == SETUP_IDLE && (!stored_reg || unlocked_reg)
                   && (TX_ENABLE || send_rise);
    end
  end

  // Key exchange: key frame end, reply burst, final confirmation
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      key_reg        <= KEY_WAIT;
      key_cnt_reg    <= CNT_ZERO;
      ENC_SERIAL_OUT <= 1'b0;
    end else begin
      case (key_reg)
        KEY_WAIT: begin
          if (key_fall) begin
            key_reg        <= KEY_REPLY;
            key_cnt_reg    <= CNT_ZERO;
            ENC_SERIAL_OUT <= 1'b1;
          end
        end
        KEY_REPLY: begin
          key_cnt_reg <= key_cnt_reg + CNT_ONE;
          if (key_cnt_reg == REPLY_CYC - CNT_ONE) begin
            key_reg        <= KEY_CONFIRM;
            key_cnt_reg    <= CNT_ZERO;
            ENC_SERIAL_OUT <= 1'b0;
          end
        end
        KEY_CONFIRM: begin
          key_cnt_reg <= key_cnt_reg + CNT_ONE;
          // Give up after one indicator period so a lost confirmation cannot hang the link
          if (key_fall || key_cnt_reg == IND_CYCLES - CNT_ONE) begin
            key_reg <= KEY_WAIT;
          end
        end
        default: begin
          key_reg <= KEY_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ind_cnt_reg      <= CNT_ZERO;
      STATUS_INDICATOR <= 1'b0;
    end else begin
      if (key_ok) begin
        ind_cnt_reg      <= IND_CYCLES - CNT_ONE;
        STATUS_INDICATOR <= 1'b1;
      end else if (ind_cnt_reg != CNT_ZERO) begin
        ind_cnt_reg      <= ind_cnt_reg - CNT_ONE;
        STATUS_INDICATOR <= 1'b1;
      end else if (setup_reg == SETUP_RUN) begin
        if (flash_reg == FLASH_CYCLES - CNT_ONE) begin
          STATUS_INDICATOR <= ~STATUS_INDICATOR;
        end
      end else begin
        STATUS_INDICATOR <= 1'b0;
      end
    end
  end

  // APB: one wait state, read data and error registered with pready
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      PRDATA   <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
    end else begin
      PREADY  <= apb_acc;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (apb_acc) begin
        if (PADDR == CTRL_ADDR) begin
          PRDATA <= {31'h0000_0000, ctrl_reg[CTRL_SHORT_BIT]};
        end else if (PADDR == STATUS_ADDR) begin
          PRDATA <= {28'h000_0000, key_reg != KEY_WAIT, setup_reg == SETUP_RUN, unlocked_reg, stored_reg};
        end else begin
          PSLVERR <= 1'b1;
        end
      end
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == CTRL_ADDR) begin
        ctrl_reg <= {31'h0000_0000, PWDATA[CTRL_SHORT_BIT]};
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  AST_SETUP_ENTER: assert property (setup_reg == SETUP_IDLE && setup_fall |=> setup_reg == SETUP_RUN)
    else $error("setup pulse did not enter setup");
  AST_FLASH: assert property (setup_reg == SETUP_RUN && ind_cnt_reg == CNT_ZERO && !key_ok
                              && flash_reg == FLASH_CYCLES - CNT_ONE
                              |=> STATUS_INDICATOR != $past(STATUS_INDICATOR))
    else $error("indicator did not toggle in setup");
  AST_STORE: assert property (setup_reg == SETUP_RUN && data_fall && ecnt_reg == LAST_ENTRY && !key_erase
                              |=> stored_reg && pin_reg == $past(entry_next) && setup_reg == SETUP_IDLE)
    else $error("fourth entry did not store code");
  AST_CANCEL: assert property (setup_reg == SETUP_RUN && !data_fall && !key_erase
                               && (setup_fall || stimer_reg == SETUP_CYCLES - CNT_ONE)
                               |=> setup_reg == SETUP_IDLE && stored_reg == $past(stored_reg))
    else $error("setup cancel misbehaved");
  AST_ERASE: assert property (key_erase |=> !stored_reg && !unlocked_reg)
    else $error("new key did not erase code");
  AST_GAP: assert property (setup_reg == SETUP_IDLE && !setup_fall && !data_fall && ecnt_reg != 2'h0
                            && gap_reg == GAP_CYCLES - CNT_ONE |=> ecnt_reg == 2'h0)
    else $error("entry gap did not restart");
  AST_MISMATCH: assert property (setup_reg == SETUP_IDLE && !setup_fall && stored_reg && !unlocked_reg
                                 && data_fall && ecnt_reg == LAST_ENTRY && entry_next != pin_reg
                                 |=> !unlocked_reg && ecnt_reg == 2'h0)
    else $error("wrong code unlocked");
  AST_LOCKOUT: assert property (unlocked_reg && !activity && !key_erase
                                && idle_reg == lock_limit - CNT_ONE |=> !unlocked_reg)
    else $error("inactivity did not relock");
  AST_LOCKED_TX: assert property (stored_reg && !unlocked_reg |=> !TX_ENABLE)
    else $error("transmitting while locked");
  AST_FREE_TX: assert property (!stored_reg && setup_reg == SETUP_IDLE && send_rise |=> TX_ENABLE)
    else $error("send without code did not transmit");
  AST_KEY_IND: assert property (key_ok |=> STATUS_INDICATOR [*8])
    else $error("indicator not held after key exchange");
  AST_REPLY: assert property (key_erase |=> ENC_SERIAL_OUT && key_reg == KEY_REPLY)
    else $error("no reply on key receipt");
endmodule
`default_nettype wire

//--- bench/user_side.sv
`timescale 1ns/100ps
`default_nettype none
// Pushbuttons, setup contact and decoder key line; released buttons sit at the pull-down level
module user_side import access_pkg::*; (
  // Clock
  input  wire logic              clock,
  // Pins toward the encoder
  output var  logic [DATA_W-1:0] data_lines,
  output var  logic              setup_button,
  output var  logic              send,
  output var  logic              key_serial_in
);
  initial begin
    data_lines    = '0;
    setup_button  = 1'b0;
    send          = 1'b0;
    key_serial_in = 1'b1;
  end

  // Six cycles each way so the three-stage input filter sees both levels
  task automatic pulse_line(input int idx);
    @(posedge clock);
    data_lines <= DATA_W'(1) << idx;
    repeat (6) @(posedge clock);
    data_lines <= '0;
    repeat (6) @(posedge clock);
  endtask

  task automatic setup_pulse();
    @(posedge clock);
    setup_button <= 1'b1;
    repeat (6) @(posedge clock);
    setup_button <= 1'b0;
    repeat (6) @(posedge clock);
  endtask

  // Key and confirm are both a falling edge on an idle-high serial line
  task automatic key_fall();
    @(posedge clock);
    key_serial_in <= 1'b0;
    repeat (6) @(posedge clock);
    key_serial_in <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  task automatic send_level(input logic v);
    @(posedge clock);
    send <= v;
  endtask
endmodule
`default_nettype wire

//--- bench/encoder_pin_access_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module encoder_pin_access_control_bench import access_pkg::*;;
  // Shortened counts, with REPLY_N left at the full REPLY_CYC; every expectation below derives from these
  localparam int SET_N   = 400;
  localparam int GAP_N   = 100;
  localparam int IND_N   = 50;
  localparam int LONG_N  = 300;
  localparam int SHORT_N = 150;
  localparam int FLASH_N = 8;
  localparam int REPLY_N = int'(REPLY_CYC);
  localparam logic [31:0] B_CODE = 32'h1 << ST_STORED_BIT;
  localparam logic [31:0] B_OPEN = 32'h1 << ST_UNLOCK_BIT;
  localparam logic [31:0] B_SET  = 32'h1 << ST_SETUP_BIT;
  localparam logic [31:0] B_KEY  = 32'h1 << ST_KEY_BIT;

  logic              clock;
  logic              rstn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [DATA_W-1:0] data_lines;
  logic              setup_button;
  logic              send;
  logic              key_serial_in;
  logic              status_indicator;
  logic              tx_enable;
  logic              enc_serial_out;
  logic [2:0]        outs;
  logic [32:0]       expq [$];
  logic [CODE_W-1:0] code;
  logic [31:0]       seed;
  int                fail_count;
  int                samples_checked;
  int                hi_cnt [3];
  int                base;

  assign outs = {enc_serial_out, tx_enable, status_indicator};

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  pin_access_top #(
    .SETUP_CYCLES      (cnt_t'(SET_N)),
    .GAP_CYCLES        (cnt_t'(GAP_N)),
    .IND_CYCLES        (cnt_t'(IND_N)),
    .LOCK_LONG_CYCLES  (cnt_t'(LONG_N)),
    .LOCK_SHORT_CYCLES (cnt_t'(SHORT_N)),
    .FLASH_CYCLES      (cnt_t'(FLASH_N))
  ) u_dut (
    .CLOCK            (clock),
    .RSTN             (rstn),
    .PSEL             (psel),
    .PENABLE          (penable),
    .PWRITE           (pwrite),
    .PADDR            (paddr),
    .PWDATA           (pwdata),
    .PRDATA           (prdata),
    .PREADY           (pready),
    .PSLVERR          (pslverr),
    .DATA_LINES       (data_lines),
    .SETUP_BUTTON     (setup_button),
    .SEND             (send),
    .STATUS_INDICATOR (status_indicator),
    .TX_ENABLE        (tx_enable),
    .KEY_SERIAL_IN    (key_serial_in),
    .ENC_SERIAL_OUT   (enc_serial_out)
  );

  user_side u_user (
    .clock         (clock),
    .data_lines    (data_lines),
    .setup_button  (setup_button),
    .send          (send),
    .key_serial_in (key_serial_in)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Read results are compared where they appear, in request order
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check("apb read", {pslverr, prdata}, expq.pop_front());
    end
    for (int i = 0; i < 3; i++) begin
      if (outs[i] === 1'b1) hi_cnt[i] <= hi_cnt[i] + 1;
    end
  end

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [32:0] exp);
    if (!wr) expq.push_back(exp);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic wait_val(input string what, input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (outs[idx] !== val && n < lim) begin
      @(posedge clock);
      n++;
    end
    check(what, {32'h0, outs[idx]}, {32'h0, val});
  endtask

  task automatic enter_code(input logic [CODE_W-1:0] c);
    for (int i = 3; i >= 0; i--) u_user.pulse_line(c[3*i +: 3]);
  endtask

  initial begin
    seed    = 32'h1231B56E;
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(STATUS_ADDR, 32'h0);
    rd(CTRL_ADDR, CTRL_RESET);
    // Random unmapped address in the upper half, then a random-direction status access
    seed = lfsr(seed);
    apb(1'b0, {1'b1, seed[10:0]}, 32'h0, {1'b1, 32'h0});
    seed = lfsr(seed);
    apb(seed[0], STATUS_ADDR, seed, 33'h0);
    apb(1'b1, CTRL_ADDR, 32'hFFFFFFFF, 33'h0);
    rd(CTRL_ADDR, 32'h1);
    rd(STATUS_ADDR, 32'h0);
    $display("test register_map done");
    u_user.send_level(1'b1);
    wait_val("tx no code", 1, 1'b1, 12);
    u_user.send_level(1'b0);
    wait_val("tx release", 1, 1'b0, 12);
    $display("test no_code_send done");
    u_user.setup_pulse();
    wait_val("flash on", 0, 1'b1, 2 * FLASH_N + 8);
    wait_val("flash off", 0, 1'b0, FLASH_N + 4);
    rd(STATUS_ADDR, B_SET);
    seed = lfsr(seed);
    code = seed[CODE_W-1:0];
    enter_code(code);
    repeat (4) @(posedge clock);
    rd(STATUS_ADDR, B_CODE);
    wait_val("flash stop", 0, 1'b0, 0);
    $display("test code_setup done");
    // Random send levels while locked; the first is forced high so a rise is certain
    for (int j = 0; j < 8; j++) begin
      seed = lfsr(seed);
      u_user.send_level(seed[0] | (j == 0));
      repeat (6) @(posedge clock);
      wait_val("tx locked", 1, 1'b0, 0);
    end
    u_user.send_level(1'b0);
    enter_code(code ^ 12'h001);
    rd(STATUS_ADDR, B_CODE);
    // Send held through the entry, as when it is wired to the data lines
    u_user.send_level(1'b1);
    enter_code(code);
    wait_val("tx after entry", 1, 1'b0, 0);
    u_user.send_level(1'b0);
    rd(STATUS_ADDR, B_CODE | B_OPEN);
    u_user.send_level(1'b1);
    wait_val("tx unlocked", 1, 1'b1, 12);
    u_user.send_level(1'b0);
    $display("test unlock done");
    // Let the short lockout run out so each pass starts locked
    repeat (SHORT_N + 10) @(posedge clock);
    for (int k = 1; k >= 0; k--) begin
      apb(1'b1, CTRL_ADDR, 32'(k), 33'h0);
      enter_code(code);
      repeat ((k ? SHORT_N : LONG_N) - 40) @(posedge clock);
      rd(STATUS_ADDR, B_CODE | B_OPEN);
      repeat (60) @(posedge clock);
      rd(STATUS_ADDR, B_CODE);
    end
    $display("test lockout done");
    u_user.pulse_line(code[11:9]);
    u_user.pulse_line(code[8:6]);
    repeat (GAP_N + 20) @(posedge clock);
    enter_code(code);
    rd(STATUS_ADDR, B_CODE | B_OPEN);
    $display("test entry_gap done");
    base = hi_cnt[2];
    u_user.key_fall();
    rd(STATUS_ADDR, B_KEY);
    wait_val("reply end", 2, 1'b0, REPLY_N + 20);
    @(posedge clock);
    check("reply len", 33'(hi_cnt[2] - base), 33'(REPLY_N));
    base = hi_cnt[0];
    u_user.key_fall();
    wait_val("key lamp", 0, 1'b1, 12);
    wait_val("key lamp end", 0, 1'b0, IND_N + 4);
    @(posedge clock);
    check("lamp len", 33'(hi_cnt[0] - base), 33'(IND_N));
    rd(STATUS_ADDR, 32'h0);
    $display("test key_exchange done");
    u_user.setup_pulse();
    u_user.pulse_line(3);
    u_user.pulse_line(5);
    u_user.setup_pulse();
    repeat (4) @(posedge clock);
    rd(STATUS_ADDR, 32'h0);
    wait_val("cancel lamp", 0, 1'b0, 0);
    u_user.setup_pulse();
    repeat (SET_N + 20) @(posedge clock);
    rd(STATUS_ADDR, 32'h0);
    wait_val("timeout lamp", 0, 1'b0, 0);
    $display("test setup_cancel done");
    test_done();
  end

  // Whole run is a few thousand cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
